/* File: logic/gitp_target.sv */
// Two-wire target port of the battery gauge with table lock and full reset
`timescale 1ns/1ns
module gitp_target import gitp_pkg::*; (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic UPDATE_HOLD,
  output logic FULL_RESET
);
  // Link domain reset
  logic rst_m_q;
  logic rst_l_q;
  logic full_rst_q;
  logic link_rst;
  // Filtered lines and edges
  logic [1:0] line_raw;
  logic [1:0] line_f;
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  // Protocol engine
  gitp_state_t state_q;
  gitp_state_t after_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic oe_n_q;
  logic mack_q;
  logic sda_zero_q;
  logic [8:0] ptr_q;
  logic rx_st;
  logic rx_done;
  logic [7:0] rx_next;
  logic addr_match;
  logic rd_done;
  // Write path and keys
  logic [7:0] hold_q;
  logic hold_ok_q;
  logic [7:0] key_hi_q;
  logic [7:0] key_lo_q;
  logic unlocked_q;
  logic word_ok;
  logic mem_we_q;
  logic [5:0] mem_wa_q;
  logic [15:0] mem_wd_q;
  logic [15:0] mem_rd;
  logic [7:0] rd_byte;
  logic cmd_hit;
  logic full_tgl_q;
  // System clock side
  logic unl_m_q;
  logic unl_s_q;
  logic tgl_m_q;
  logic tgl_s_q;
  logic tgl_p_q;
  logic hold_out_q;
  logic full_out_q;

  // Reset brought into the link domain; full reset adds to it
  always_ff @(posedge LINK_CLK) begin
    rst_m_q <= RESET;
    rst_l_q <= rst_m_q;
  end

  assign link_rst = rst_l_q | full_rst_q;

  // Two-flop synchroniser and glitch filter per line
  assign line_raw = {SDA_IN, SCL_IN};

  for (genvar i = 0; i < 2; i++) begin : g_line
    logic s1_q;
    logic s2_q;
    logic f_q;
    logic [2:0] cnt_q;
    always_ff @(posedge LINK_CLK) begin
      if (rst_l_q) begin
        s1_q <= 1'b1;
        s2_q <= 1'b1;
        f_q <= 1'b1;
        cnt_q <= 3'h0;
      end else begin
        s1_q <= line_raw[i];
        s2_q <= s1_q;
        if (s2_q == f_q) begin
          cnt_q <= 3'h0;
        end else if (cnt_q == FILT_CYC - FILT_STEP) begin
          f_q <= s2_q;
          cnt_q <= 3'h0;
        end else begin
          cnt_q <= cnt_q + FILT_STEP;
        end
      end
    end
    assign line_f[i] = f_q;
  end

  assign scl_f = line_f[0];
  assign sda_f = line_f[1];

  always_ff @(posedge LINK_CLK) begin
    if (rst_l_q) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // Bus events, all on the filtered controller clock
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_evt = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_evt = scl_f & scl_p_q & ~sda_p_q & sda_f;

  assign rx_st = (state_q == ST_ADDR) | (state_q == ST_PTR) | (state_q == ST_WDATA);
  assign rx_done = rx_st & scl_fall & (bit_q == BYTE_BITS);
  assign rx_next = {shift_q[6:0], sda_f};
  assign addr_match = shift_q[7:1] == TGT_ADDR_W[7:1];
  assign rd_done = (state_q == ST_RDATA) & scl_fall & (bit_q == BYTE_BITS - BIT_STEP);

  // Read byte: MSB at even, pad above the stored space
  always_comb begin
    if (ptr_q > MEM_TOP) begin
      rd_byte = READ_PAD;
    end else if (ptr_q[0]) begin
      rd_byte = mem_rd[7:0];
    end else begin
      rd_byte = mem_rd[15:8];
    end
  end

  // Protocol engine
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      oe_n_q <= 1'b1;
      mack_q <= 1'b0;
    end else if (start_evt) begin
      state_q <= ST_ADDR;
      bit_q <= 4'h0;
      oe_n_q <= 1'b1;
    end else if (stop_evt) begin
      state_q <= ST_IDLE;
      oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise && (bit_q != BYTE_BITS)) begin
            shift_q <= rx_next;
            bit_q <= bit_q + BIT_STEP;
          end else if (rx_done) begin
            if ((state_q == ST_ADDR) && !addr_match) begin
              state_q <= ST_IDLE;
            end else begin
              oe_n_q <= 1'b0;
              state_q <= ST_ACK;
              if (state_q == ST_ADDR) begin
                after_q <= shift_q[0] ? ST_RDATA : ST_PTR;
              end else begin
                after_q <= ST_WDATA;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (after_q == ST_RDATA) begin
              tx_q <= rd_byte;
              oe_n_q <= rd_byte[7];
              state_q <= ST_RDATA;
            end else begin
              oe_n_q <= 1'b1;
              state_q <= after_q;
            end
          end
        end
        ST_RDATA: begin
          if (rd_done) begin
            oe_n_q <= 1'b1;
            bit_q <= 4'h0;
            state_q <= ST_RACK;
          end else if (scl_fall) begin
            bit_q <= bit_q + BIT_STEP;
            tx_q <= {tx_q[6:0], 1'b0};
            oe_n_q <= tx_q[6];
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f;
          end else if (scl_fall) begin
            if (mack_q) begin
              tx_q <= rd_byte;
              oe_n_q <= rd_byte[7];
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          bit_q <= 4'h0;
        end
      endcase
    end
  end

  // Register pointer, loaded from the pointer byte
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      ptr_q <= PTR_RESET;
    end else if (rx_done && (state_q == ST_PTR)) begin
      ptr_q <= {1'b0, shift_q};
    end else if ((rx_done && (state_q == ST_WDATA)) || rd_done) begin
      ptr_q <= ptr_q[8] ? ptr_q : ptr_q + PTR_STEP;
    end
  end

  // Word may be committed at this odd address
  assign word_ok = !ptr_q[8] && (ptr_q <= WR_LIMIT) &&
    ((ptr_q < KEY_LO_ADDR) || ((ptr_q >= TABLE_BASE) && unlocked_q));

  // Write path: pair even and odd bytes into one word
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      hold_q <= 8'h00;
      hold_ok_q <= 1'b0;
      key_hi_q <= KEY_RELOCK;
      key_lo_q <= KEY_RELOCK;
      mem_we_q <= 1'b0;
      mem_wa_q <= 6'h00;
      mem_wd_q <= 16'h0000;
    end else begin
      mem_we_q <= 1'b0;
      if (start_evt || (rx_done && (state_q == ST_PTR))) begin
        hold_ok_q <= 1'b0;
      end else if (rx_done && (state_q == ST_WDATA)) begin
        if (ptr_q == KEY_HI_ADDR) begin
          key_hi_q <= shift_q;
        end
        if (ptr_q == KEY_LO_ADDR) begin
          key_lo_q <= shift_q;
        end
        if (!ptr_q[0]) begin
          hold_q <= shift_q;
          hold_ok_q <= 1'b1;
        end else begin
          hold_ok_q <= 1'b0;
          if (hold_ok_q && word_ok) begin
            mem_we_q <= 1'b1;
            mem_wa_q <= ptr_q[6:1];
            mem_wd_q <= {hold_q, shift_q};
          end
        end
      end
    end
  end

  // Table lock state
  always_ff @(posedge LINK_CLK) begin
    if (link_rst) begin
      unlocked_q <= 1'b0;
    end else if ((key_hi_q == KEY_HI_UNLOCK) && (key_lo_q == KEY_LO_UNLOCK)) begin
      unlocked_q <= 1'b1;
    end else if ((key_hi_q == KEY_RELOCK) && (key_lo_q == KEY_RELOCK)) begin
      unlocked_q <= 1'b0;
    end
  end

  // Full reset on the last bit of the command code
  assign cmd_hit = (state_q == ST_WDATA) && scl_rise && (bit_q == BYTE_BITS - BIT_STEP) &&
    (ptr_q == CMD_LO_ADDR) && hold_ok_q && (hold_q == CMD_CODE_HI) &&
    (rx_next == CMD_CODE_LO);

  always_ff @(posedge LINK_CLK) begin
    if (rst_l_q) begin
      full_rst_q <= 1'b0;
      full_tgl_q <= 1'b0;
      sda_zero_q <= 1'b0;
    end else begin
      full_rst_q <= cmd_hit;
      sda_zero_q <= 1'b0;
      if (cmd_hit) begin
        full_tgl_q <= ~full_tgl_q;
      end
    end
  end

  gitp_regmem u_mem (
    .clk(LINK_CLK),
    .clr(link_rst),
    .we(mem_we_q),
    .waddr(mem_wa_q),
    .wdata(mem_wd_q),
    .raddr(ptr_q[6:1]),
    .rdata(mem_rd)
  );

  // Open-drain data pin: drive low only
  assign SDA_OUT = sda_zero_q;
  assign SDA_OE_N = oe_n_q;

  // System clock side: lock level and reset event cross over
  always_ff @(posedge CLK) begin
    if (RESET) begin
      unl_m_q <= 1'b0;
      unl_s_q <= 1'b0;
      hold_out_q <= 1'b0;
    end else begin
      unl_m_q <= unlocked_q;
      unl_s_q <= unl_m_q;
      hold_out_q <= unl_s_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_p_q <= 1'b0;
      full_out_q <= 1'b0;
    end else begin
      tgl_m_q <= full_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_p_q <= tgl_s_q;
      full_out_q <= tgl_s_q ^ tgl_p_q;
    end
  end

  assign UPDATE_HOLD = hold_out_q;
  assign FULL_RESET = full_out_q;
endmodule

/* File: common/gitp_pkg.sv */
// Constants and state type for the gauge two-wire target port
package gitp_pkg;
  // Target address bytes, write and read direction
  localparam logic [7:0] TGT_ADDR_W = 8'h6C;
  localparam logic [7:0] TGT_ADDR_R = 8'h6D;
  // Register pointer offsets
  localparam logic [8:0] KEY_LO_ADDR = 9'h03E;
  localparam logic [8:0] KEY_HI_ADDR = 9'h03F;
  localparam logic [8:0] TABLE_BASE = 9'h040;
  localparam logic [8:0] WR_LIMIT = 9'h04F;
  localparam logic [8:0] MEM_TOP = 9'h04F;
  localparam logic [8:0] CMD_HI_ADDR = 9'h0FE;
  localparam logic [8:0] CMD_LO_ADDR = 9'h0FF;
  localparam logic [8:0] PTR_RESET = 9'h000;
  localparam logic [8:0] PTR_STEP = 9'h001;
  // Key and command codes
  localparam logic [7:0] KEY_HI_UNLOCK = 8'h57;
  localparam logic [7:0] KEY_LO_UNLOCK = 8'h4A;
  localparam logic [7:0] KEY_RELOCK = 8'h00;
  localparam logic [7:0] CMD_CODE_HI = 8'h54;
  localparam logic [7:0] CMD_CODE_LO = 8'h00;
  localparam logic [7:0] READ_PAD = 8'hFF;
  // Register storage layout
  localparam int MEM_WORDS = 40;
  localparam logic [15:0] MEM_RESET = 16'h0000;
  localparam logic [15:0] MEM_UNMAPPED = 16'hFFFF;
  // Bit counting
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;
  // Glitch filter timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINK_PERIOD_NS = 15;
  localparam int GLITCH_NS = 50;
  localparam logic [2:0] FILT_CYC =
    3'((GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [2:0] FILT_STEP = 3'h1;
  // Protocol states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_PTR   = 7'h04,
    ST_WDATA = 7'h08,
    ST_ACK   = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK  = 7'h40
  } gitp_state_t;
endpackage

/* File: logic/gitp_regmem.sv */
// Word storage for the writable register space of the target port
`timescale 1ns/1ns
module gitp_regmem import gitp_pkg::*; (
  input wire logic clk,
  input wire logic clr,
  input wire logic we,
  input wire logic [5:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [5:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem_q [MEM_WORDS];

  // One word per entry, cleared on any reset
  for (genvar i = 0; i < MEM_WORDS; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (clr) begin
        mem_q[i] <= MEM_RESET;
      end else if (we && (waddr == 6'(i))) begin
        mem_q[i] <= wdata;
      end
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (clr) begin
      rdata <= MEM_RESET;
    end else if (int'(raddr) < MEM_WORDS) begin
      rdata <= mem_q[raddr];
    end else begin
      rdata <= MEM_UNMAPPED;
    end
  end
endmodule

/* File: testbench/gitp_checker.sv */
// Assertions on the target port pins
`timescale 1ns/1ns
module gitp_checker (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LINK_CLK,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic UPDATE_HOLD,
  input wire logic FULL_RESET
);
  logic [8:0] low_q;
  // Length of the current pull-low run
  always_ff @(posedge CLK) begin
    if (RESET || SDA_OE_N) begin
      low_q <= 9'h000;
    end else if (low_q != 9'h1FF) begin
      low_q <= low_q + 9'h001;
    end
  end
  AST_OD_LOW: assert property (@(posedge LINK_CLK) disable iff (RESET)
    !SDA_OE_N |-> !SDA_OUT) else $error("pin driven high");
  AST_TAKE_LOW: assert property (@(posedge LINK_CLK) disable iff (RESET)
    $fell(SDA_OE_N) |-> !SCL_IN) else $error("drive begun in clock high");
  AST_FREE_LOW: assert property (@(posedge LINK_CLK) disable iff (RESET)
    $rose(SDA_OE_N) |-> !SCL_IN) else $error("drive ended in clock high");
  AST_ACK_STEADY: assert property (@(posedge LINK_CLK) disable iff (RESET)
    SCL_IN && !SDA_OE_N |=> !SDA_OE_N) else $error("drive lost in clock high");
  AST_FR_PULSE: assert property (@(posedge CLK) disable iff (RESET)
    FULL_RESET |=> !FULL_RESET) else $error("reset pulse too long");
  AST_FR_UNHOLD: assert property (@(posedge CLK) disable iff (RESET)
    FULL_RESET |-> ##[0:8] !UPDATE_HOLD) else $error("hold kept after reset");
  AST_FR_NO_ACK: assert property (@(posedge CLK) disable iff (RESET)
    FULL_RESET |-> SDA_OE_N [*8] ##1 SDA_OE_N [*8] ##1 SDA_OE_N [*8])
    else $error("reset code acknowledged");
  AST_RESET_CLEAR: assert property (@(posedge CLK) disable iff (RESET)
    $fell(RESET) |-> !FULL_RESET && !UPDATE_HOLD) else $error("outputs not reset");
  AST_DRIVE_BOUND: assert property (@(posedge CLK) disable iff (RESET)
    low_q < 9'h10E) else $error("line held low too long");
  cover property (@(posedge CLK) FULL_RESET);
  cover property (@(posedge CLK) $rose(UPDATE_HOLD));
  cover property (@(posedge LINK_CLK) $fell(SDA_IN) && SCL_IN);
endmodule

/* File: testbench/gitp_ctrl_model.sv */
// Bus controller model: clock, start, stop and byte transfers
`timescale 1ns/1ns
module gitp_ctrl_model #(
  parameter int QTR_NS = 700
) (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic beg_frame;
    @(posedge clk) #1;
    #QTR_NS sda_rel = 1'b1;
    #QTR_NS scl = 1'b1;
    #QTR_NS sda_rel = 1'b0;
    #QTR_NS scl = 1'b0;
  endtask
  task automatic end_frame;
    #QTR_NS sda_rel = 1'b0;
    #QTR_NS scl = 1'b1;
    #QTR_NS sda_rel = 1'b1;
    #QTR_NS;
  endtask
  task automatic xbit(input logic b, output logic r);
    #QTR_NS sda_rel = b;
    #QTR_NS scl = 1'b1;
    #QTR_NS r = sda;
    #QTR_NS scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ack_in,
                       output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(ack_in, ack);
  endtask
endmodule

/* File: testbench/gauge_i2c_target_port_bench.sv */
// Self-checking bench for the gauge two-wire target port
`timescale 1ns/1ns
module gauge_i2c_target_port_bench import gitp_pkg::*; ;
  logic CLK, RESET, LINK_CLK, scl, sda_rel, sda, SDA_OUT, SDA_OE_N;
  logic UPDATE_HOLD, FULL_RESET, fr_scl, a;
  logic [7:0] q;
  logic [31:0] w;
  int fails, samples_checked, fr_n, exp_fr, khi, klo, unl, hb, have, r;
  int m[0:79];
  assign sda = sda_rel & (SDA_OE_N | SDA_OUT);
  gitp_target gitp_target_inst (.CLK(CLK), .RESET(RESET), .LINK_CLK(LINK_CLK),
    .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
    .UPDATE_HOLD(UPDATE_HOLD), .FULL_RESET(FULL_RESET));
  gitp_ctrl_model ctrl (.clk(CLK), .sda(sda), .scl(scl), .sda_rel(sda_rel));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    LINK_CLK = 1'b0;
    #3;
    forever begin
      #7 LINK_CLK = 1'b1;
      #8 LINK_CLK = 1'b0;
    end
  end
  always @(posedge CLK) begin
    if (FULL_RESET === 1'b1) begin
      fr_n++;
      fr_scl = scl;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic tx(input logic [7:0] d, input logic ack_exp);
    ctrl.xbyte(d, 1'b1, q, a);
    chk(a, !ack_exp);
  endtask
  // Model of one written byte at pointer p
  task automatic put(input int p, input logic [7:0] b);
    logic ak;
    ak = !(p == CMD_LO_ADDR && b == CMD_CODE_LO && have && hb == CMD_CODE_HI);
    tx(b, ak);
    if (!ak) begin
      exp_fr++;
      m = '{default: 0};
      khi = 0;
      klo = 0;
      unl = 0;
      chk(fr_scl, 1'b1);
    end
    chk(16'(fr_n), 16'(exp_fr));
    if (p == KEY_HI_ADDR) khi = b;
    if (p == KEY_LO_ADDR) klo = b;
    if (khi == KEY_HI_UNLOCK && klo == KEY_LO_UNLOCK) unl = 1;
    if (khi == 0 && klo == 0) unl = 0;
    if (p[0] && have && p <= WR_LIMIT && (p < KEY_LO_ADDR || (p >= TABLE_BASE && unl))) begin
      m[p - 1] = hb;
      m[p] = b;
    end
    have = !p[0];
    hb = b;
  endtask
  task automatic wr(input int p, input logic [7:0] d[$]);
    ctrl.beg_frame();
    tx(TGT_ADDR_W, 1'b1);
    if (a) begin
      ctrl.beg_frame();
      tx(TGT_ADDR_W, 1'b1);
    end
    tx(p[7:0], 1'b1);
    have = 0;
    foreach (d[i]) put(p + i, d[i]);
    ctrl.end_frame();
  endtask
  task automatic rd(input int p, input int n);
    ctrl.beg_frame();
    tx(TGT_ADDR_W, 1'b1);
    tx(p[7:0], 1'b1);
    ctrl.beg_frame();
    tx(TGT_ADDR_R, 1'b1);
    for (int i = 0; i < n; i++) begin
      ctrl.xbyte(READ_PAD, i == n - 1, q, a);
      chk(q, 16'((p + i <= MEM_TOP) ? m[p + i] : READ_PAD));
    end
    ctrl.end_frame();
  endtask
  initial begin
    repeat (90000) @(posedge CLK);
    fails++;
    report_and_stop();
  end
  initial begin
    RESET = 1'b1;
    void'($urandom(32'h388019A0));
    repeat (8) @(posedge CLK);
    #1 RESET = 1'b0;
    repeat (10) @(posedge CLK);
    chk(UPDATE_HOLD, 1'b0);
    w = $urandom;
    wr(8'h00, '{8'h12, 8'h34, w[15:8], w[7:0], 8'h56});
    rd(8'h00, 6);
    r = 2 * ($urandom % 31);
    wr(r, '{w[31:24], w[23:16]});
    wr(r, '{8'hA5});
    rd(r, 2);
    wr(8'h4E, '{8'hC3, 8'h5A});
    rd(8'h4E, 2);
    wr(KEY_HI_ADDR, '{KEY_HI_UNLOCK});
    chk(UPDATE_HOLD, 1'b0);
    wr(KEY_LO_ADDR, '{KEY_LO_UNLOCK});
    chk(UPDATE_HOLD, 1'b1);
    wr(8'h4E, '{8'hC3, 8'h5A, 8'h77, 8'h88});
    rd(8'h4C, 6);
    rd(8'hFE, 3);
    wr(KEY_HI_ADDR, '{KEY_RELOCK});
    chk(UPDATE_HOLD, 1'b1);
    wr(KEY_LO_ADDR, '{KEY_RELOCK});
    chk(UPDATE_HOLD, 1'b0);
    foreach (q[i]) begin
      ctrl.beg_frame();
      tx(TGT_ADDR_W ^ (8'h01 << i), i == 0);
      tx(8'h00, 1'b0);
      ctrl.end_frame();
    end
    wr(CMD_HI_ADDR, '{CMD_CODE_HI, 8'h01});
    wr(KEY_HI_ADDR, '{KEY_HI_UNLOCK});
    wr(KEY_LO_ADDR, '{KEY_LO_UNLOCK});
    wr(CMD_HI_ADDR, '{CMD_CODE_HI, CMD_CODE_LO});
    chk(UPDATE_HOLD, 1'b0);
    rd(8'h00, 4);
    report_and_stop();
  end
endmodule
bind gitp_target gitp_checker gitp_checker_inst (.CLK(CLK), .RESET(RESET),
  .LINK_CLK(LINK_CLK), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE_N(SDA_OE_N), .UPDATE_HOLD(UPDATE_HOLD), .FULL_RESET(FULL_RESET));
